// >>> pkg/sdc_pkg.sv
// sdc_pkg: register map, field layout, reset values and sdram command codes
// assumes: a single master clock domain; the sdram clock is sampled as data
package sdc_pkg;

	// ****************************************
	// register map (byte addresses)
	// ****************************************
	localparam int          ADDR_W        = 8;               // register window is 256 bytes
	localparam logic [7:0]  OFF_MODE      = 8'h00;           // command_mode_register
	localparam logic [7:0]  OFF_PERIOD    = 8'h04;           // refresh_period_register
	localparam logic [7:0]  OFF_TIMING    = 8'h08;           // timing_config_register
	localparam logic [7:0]  OFF_SELFREF   = 8'h0c;           // self_refresh_trigger_register
	localparam logic [7:0]  OFF_LOWPWR    = 8'h10;           // low_power_register
	localparam logic [7:0]  OFF_IRQ_EN    = 8'h14;           // irq_enable_register
	localparam logic [7:0]  OFF_IRQ_DIS   = 8'h18;           // irq_disable_register
	localparam logic [7:0]  OFF_IRQ_MASK  = 8'h1c;           // irq_mask_register
	localparam logic [7:0]  OFF_IRQ_STAT  = 8'h20;           // irq_status_register

	// ****************************************
	// fields and reset values
	// ****************************************
	localparam int          MODE_LSB      = 0;               // command mode field position
	localparam int          MODE_W        = 4;               // command mode field width
	localparam int          DBW_BIT       = 4;               // bus_width_select position
	localparam int          COUNT_W       = 12;              // refresh count width
	localparam int          ERR_BIT       = 0;               // refresh_error_flag position
	localparam logic [4:0]  MODE_RST      = 5'h10;           // 16-bit bus, normal mode
	localparam logic [11:0] COUNT_RST     = 12'h800;         // refresh count reset
	localparam logic [31:0] TIMING_RST    = 32'h2a99c140;    // timing config reset

	// command mode values
	localparam logic [3:0]  CM_NORMAL     = 4'h0;
	localparam logic [3:0]  CM_NOP        = 4'h1;
	localparam logic [3:0]  CM_PRECHARGE  = 4'h2;
	localparam logic [3:0]  CM_LOAD_MODE  = 4'h3;
	localparam logic [3:0]  CM_REFRESH    = 4'h4;

	// ****************************************
	// sdram command pins and codes
	// ****************************************
	typedef struct packed {
		logic cs_n;                                       // chip select, low active
		logic ras_n;                                      // row strobe, low active
		logic cas_n;                                      // column strobe, low active
		logic we_n;                                       // write enable, low active
	} sdc_cmd_type;

	localparam sdc_cmd_type CMD_NOP       = 4'b0111;
	localparam sdc_cmd_type CMD_ACTIVE    = 4'b0011;
	localparam sdc_cmd_type CMD_READ      = 4'b0101;
	localparam sdc_cmd_type CMD_WRITE     = 4'b0100;
	localparam sdc_cmd_type CMD_PRECHARGE = 4'b0010;
	localparam sdc_cmd_type CMD_REFRESH   = 4'b0001;
	localparam sdc_cmd_type CMD_LOAD_MODE = 4'b0000;
	localparam int          PRE_ALL_BIT   = 10;              // address bit selecting all banks

	// access sequencer states
	typedef enum logic [1:0] {
		SEQ_IDLE,
		SEQ_RW,
		SEQ_PRE
	} sdc_seq_type;

endpackage

// >>> logic/sdc_mode_refresh.sv
// sdc_mode_refresh: command mode, refresh timer and register slave of the sdram controller
// assumes: axi4-lite master on clock; access port on clock; sdram clock and data pins
// arrive from outside and are sampled through two flip-flops
//
// How it works
// - nine registers at 0x00..0x20, rest reserved
// - four-bit mode field picks access command
// - mode zero runs activate, read/write, precharge
// - mode one issues only nop
// - mode two issues precharge of all banks
// - mode three loads mode register from offset
// - mode four issues auto-refresh; software precharged first
// - width bit selects 32 or 16 bit data
// - 12-bit count reloads periodic refresh timer
// - each timer pulse starts a refresh
// - no timer refresh until count field written
// - missed refresh before next raises error
// - error flag sticky, cleared by status read
module sdc_mode_refresh (
	input  wire logic                clock,          // master clock, 125 mhz
	input  wire logic                reset,          // asynchronous, active high
	// axi4-lite slave
	input  wire logic [7:0]          s_awaddr,
	input  wire logic                s_awvalid,
	output logic                     s_awready,
	input  wire logic [31:0]         s_wdata,
	input  wire logic [3:0]          s_wstrb,
	input  wire logic                s_wvalid,
	output logic                     s_wready,
	output logic [1:0]               s_bresp,
	output logic                     s_bvalid,
	input  wire logic                s_bready,
	input  wire logic [7:0]          s_araddr,
	input  wire logic                s_arvalid,
	output logic                     s_arready,
	output logic [31:0]              s_rdata,
	output logic [1:0]               s_rresp,
	output logic                     s_rvalid,
	input  wire logic                s_rready,
	// access port from the on-chip master into sdram space
	input  wire logic                acc_valid,
	input  wire logic                acc_write,
	input  wire logic [25:0]         acc_addr,       // offset from sdram base
	input  wire logic [31:0]         acc_wdata,
	output logic                     acc_ready,      // one-cycle pulse, access done
	output logic [31:0]              acc_rdata,
	// sdram side
	input  wire logic                sdram_clk_in,   // link clock, sampled
	output sdc_pkg::sdc_cmd_type     sdram_cmd,
	output logic [12:0]              sdram_a,
	output logic [1:0]               sdram_ba,
	input  wire logic [31:0]         sdram_dq_in,
	output logic [31:0]              sdram_dq_out,
	output logic [31:0]              sdram_dq_oe,
	output logic                     bus_width_16,
	output logic                     irq
);

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		logic                        aw_got;         // write address latched
		logic [7:0]                  aw_addr;
		logic                        w_got;          // write data latched
		logic [31:0]                 w_data;
		logic [3:0]                  w_strb;
		logic                        awready;
		logic                        wready;
		logic                        bvalid;
		logic                        arready;
		logic                        rvalid;
		logic [31:0]                 rdata;
		logic [4:0]                  mode;           // width bit and command mode
		logic [11:0]                 count;          // refresh count
		logic                        armed;          // count written at least once
		logic [31:0]                 timing;         // timing config, stored only
		logic                        lowpwr;         // low-power bit, stored only
		logic                        imask;          // refresh error enable
		logic                        istat;          // refresh error flag
		logic                        irq;
		logic [11:0]                 tmr;            // refresh down counter
		logic                        tick;           // refresh pulse
		logic                        ref_pend;       // refresh waiting for the link
		logic                        clk_s1;         // link clock synchroniser
		logic                        clk_s2;
		logic                        clk_prev;
		logic [31:0]                 dq_s1;          // data pin synchroniser
		logic [31:0]                 dq_s2;
		sdc_pkg::sdc_seq_type        seq;
		sdc_pkg::sdc_cmd_type        cmd;
		logic [12:0]                 a;
		logic [1:0]                  ba;
		logic [31:0]                 dq_out;
		logic [31:0]                 dq_oe;
		logic                        acc_ready;
		logic [31:0]                 acc_rdata;
	} sdc_state_type;

	sdc_state_type st_r;
	sdc_state_type st_nxt;

	// byte-lane merge for writable registers
	function automatic logic [31:0] sdc_merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return res;
	endfunction

	// ****************************************
	// next-state logic
	// ****************************************
	logic        wr_fire;                             // both write halves present
	logic        rd_fire;                             // read address taken
	logic        link_edge;                           // rising edge of sampled link clock
	logic        err_set;                             // refresh missed
	logic        err_clr;                             // status register read
	logic        tmr_load;                            // period write reloads the timer this cycle
	logic [31:0] wmerged;
	logic [31:0] rd_val;

	// combinational update of the whole state
	always_comb begin
		st_nxt    = st_r;
		wr_fire   = st_r.aw_got && st_r.w_got && !st_r.bvalid;
		rd_fire   = s_arvalid && st_r.arready;
		link_edge = st_r.clk_s2 && !st_r.clk_prev;
		err_set   = 1'b0;
		err_clr   = 1'b0;
		tmr_load  = 1'b0;
		wmerged   = 32'h0;
		rd_val    = 32'h0;

		// synchronisers: first stage read only by second
		st_nxt.clk_s1   = sdram_clk_in;
		st_nxt.clk_s2   = st_r.clk_s1;
		st_nxt.clk_prev = st_r.clk_s2;
		st_nxt.dq_s1    = sdram_dq_in;
		st_nxt.dq_s2    = st_r.dq_s1;

		// address and data channels taken in either order
		if (s_awvalid && st_r.awready) begin
			st_nxt.aw_got  = 1'b1;
			st_nxt.aw_addr = s_awaddr;
		end
		if (s_wvalid && st_r.wready) begin
			st_nxt.w_got  = 1'b1;
			st_nxt.w_data = s_wdata;
			st_nxt.w_strb = s_wstrb;
		end

		// register write
		if (wr_fire) begin
			st_nxt.aw_got = 1'b0;
			st_nxt.w_got  = 1'b0;
			st_nxt.bvalid = 1'b1;
			case ({st_r.aw_addr[7:2], 2'b00})
				sdc_pkg::OFF_MODE: begin
					wmerged     = sdc_merge({27'h0, st_r.mode}, st_r.w_data, st_r.w_strb);
					st_nxt.mode = wmerged[4:0];
				end
				sdc_pkg::OFF_PERIOD: begin
					wmerged      = sdc_merge({20'h0, st_r.count}, st_r.w_data, st_r.w_strb);
					st_nxt.count = wmerged[11:0];
					if (st_r.w_strb[1:0] != 2'b00) begin
						st_nxt.armed = 1'b1;
						tmr_load     = 1'b1;
						st_nxt.tmr   = wmerged[11:0];
					end
				end
				sdc_pkg::OFF_TIMING: begin
					st_nxt.timing = sdc_merge(st_r.timing, st_r.w_data, st_r.w_strb);
				end
				sdc_pkg::OFF_LOWPWR: begin
					if (st_r.w_strb[0]) begin
						st_nxt.lowpwr = st_r.w_data[0];
					end
				end
				sdc_pkg::OFF_IRQ_EN: begin
					if (st_r.w_strb[0] && st_r.w_data[sdc_pkg::ERR_BIT]) begin
						st_nxt.imask = 1'b1;
					end
				end
				sdc_pkg::OFF_IRQ_DIS: begin
					if (st_r.w_strb[0] && st_r.w_data[sdc_pkg::ERR_BIT]) begin
						st_nxt.imask = 1'b0;
					end
				end
				default: begin
					// self refresh trigger, read-only and reserved offsets ignore writes
				end
			endcase
		end
		if (st_r.bvalid && s_bready) begin
			st_nxt.bvalid = 1'b0;
		end
		st_nxt.awready = !st_nxt.aw_got && !st_nxt.bvalid;
		st_nxt.wready  = !st_nxt.w_got && !st_nxt.bvalid;

		// register read, one cycle after the address is taken
		if (rd_fire) begin
			case ({s_araddr[7:2], 2'b00})
				sdc_pkg::OFF_MODE:     rd_val = {27'h0, st_r.mode};
				sdc_pkg::OFF_PERIOD:   rd_val = {20'h0, st_r.count};
				sdc_pkg::OFF_TIMING:   rd_val = st_r.timing;
				sdc_pkg::OFF_LOWPWR:   rd_val = {31'h0, st_r.lowpwr};
				sdc_pkg::OFF_IRQ_MASK: rd_val = {31'h0, st_r.imask};
				sdc_pkg::OFF_IRQ_STAT: begin
					rd_val  = {31'h0, st_r.istat};
					err_clr = 1'b1;
				end
				default:               rd_val = 32'h0;
			endcase
			st_nxt.rdata  = rd_val;
			st_nxt.rvalid = 1'b1;
		end
		if (st_r.rvalid && s_rready) begin
			st_nxt.rvalid = 1'b0;
		end
		st_nxt.arready = !st_nxt.rvalid;

		// refresh timer: pulse every count cycles once armed
		st_nxt.tick = 1'b0;
		if (!tmr_load && st_r.armed && st_r.count != 12'h000) begin
			if (st_r.tmr <= 12'h001) begin
				st_nxt.tmr  = st_r.count;
				st_nxt.tick = 1'b1;
			end else begin
				st_nxt.tmr = st_r.tmr - 12'h001;
			end
		end
		if (st_r.tick) begin
			st_nxt.ref_pend = 1'b1;
			err_set         = st_r.ref_pend;
		end

		// sdram sequencer, moves on sampled link clock edges
		st_nxt.acc_ready = 1'b0;
		if (link_edge) begin
			st_nxt.cmd   = sdc_pkg::CMD_NOP;
			st_nxt.dq_oe = 32'h0;
			case (st_r.seq)
				sdc_pkg::SEQ_IDLE: begin
					if (st_r.ref_pend) begin
						st_nxt.cmd      = sdc_pkg::CMD_REFRESH;
						st_nxt.ref_pend = st_r.tick;                  // a tick on this edge stays queued
					end else if (acc_valid) begin
						case (st_r.mode[3:0])
							sdc_pkg::CM_NORMAL: begin
								st_nxt.cmd = sdc_pkg::CMD_ACTIVE;
								st_nxt.ba  = acc_addr[25:24];
								st_nxt.a   = acc_addr[23:11];
								st_nxt.seq = sdc_pkg::SEQ_RW;
							end
							sdc_pkg::CM_PRECHARGE: begin
								st_nxt.cmd = sdc_pkg::CMD_PRECHARGE;
								st_nxt.a   = 13'h0400;
								st_nxt.acc_ready = 1'b1;
							end
							sdc_pkg::CM_LOAD_MODE: begin
								st_nxt.cmd = sdc_pkg::CMD_LOAD_MODE;
								st_nxt.a   = acc_addr[12:0];
								st_nxt.ba  = acc_addr[14:13];
								st_nxt.acc_ready = 1'b1;
							end
							sdc_pkg::CM_REFRESH: begin
								st_nxt.cmd = sdc_pkg::CMD_REFRESH;
								st_nxt.acc_ready = 1'b1;
							end
							default: begin
								st_nxt.cmd = sdc_pkg::CMD_NOP;
								st_nxt.acc_ready = 1'b1;
							end
						endcase
					end
				end
				sdc_pkg::SEQ_RW: begin
					st_nxt.cmd = acc_write ? sdc_pkg::CMD_WRITE : sdc_pkg::CMD_READ;
					st_nxt.a   = st_r.mode[sdc_pkg::DBW_BIT] ? {3'h0, acc_addr[10:1]}
					                                          : {3'h0, acc_addr[11:2]};
					if (acc_write) begin
						st_nxt.dq_out = acc_wdata;
						st_nxt.dq_oe  = st_r.mode[sdc_pkg::DBW_BIT] ? 32'h0000ffff
						                                             : 32'hffffffff;
					end
					st_nxt.seq = sdc_pkg::SEQ_PRE;
				end
				sdc_pkg::SEQ_PRE: begin
					st_nxt.cmd       = sdc_pkg::CMD_PRECHARGE;
					st_nxt.a         = 13'h0400;
					st_nxt.acc_rdata = st_r.mode[sdc_pkg::DBW_BIT] ? {16'h0, st_r.dq_s2[15:0]}
					                                               : st_r.dq_s2;
					st_nxt.acc_ready = 1'b1;
					st_nxt.seq       = sdc_pkg::SEQ_IDLE;
				end
				default: begin
					st_nxt.seq = sdc_pkg::SEQ_IDLE;
				end
			endcase
		end

		// sticky error: a new miss wins over the clearing read
		if (err_set) begin
			st_nxt.istat = 1'b1;
		end else if (err_clr) begin
			st_nxt.istat = 1'b0;
		end
		st_nxt.irq = st_nxt.istat && st_nxt.imask;
	end

	// ****************************************
	// state register
	// ****************************************
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			st_r        <= '0;
			st_r.mode   <= sdc_pkg::MODE_RST;
			st_r.count  <= sdc_pkg::COUNT_RST;
			st_r.timing <= sdc_pkg::TIMING_RST;
			st_r.seq    <= sdc_pkg::SEQ_IDLE;
			st_r.cmd    <= sdc_pkg::CMD_NOP;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ****************************************
	// outputs, straight from flip-flops; bresp and rresp tied to zero
	// ****************************************
	assign s_awready    = st_r.awready;
	assign s_wready     = st_r.wready;
	assign s_bvalid     = st_r.bvalid;
	assign s_bresp      = 2'h0;
	assign s_arready    = st_r.arready;
	assign s_rvalid     = st_r.rvalid;
	assign s_rdata      = st_r.rdata;
	assign s_rresp      = 2'h0;
	assign acc_ready    = st_r.acc_ready;
	assign acc_rdata    = st_r.acc_rdata;
	assign sdram_cmd    = st_r.cmd;
	assign sdram_a      = st_r.a;
	assign sdram_ba     = st_r.ba;
	assign sdram_dq_out = st_r.dq_out;
	assign sdram_dq_oe  = st_r.dq_oe;
	assign bus_width_16 = st_r.mode[sdc_pkg::DBW_BIT];
	assign irq          = st_r.irq;

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	// an access in mode m taken at a link edge in idle
	sequence s_take(logic [3:0] m);
		link_edge && st_r.seq == sdc_pkg::SEQ_IDLE && acc_valid && !st_r.ref_pend
		&& st_r.mode[3:0] == m;
	endsequence

	a_nop_mode: assert property (s_take(sdc_pkg::CM_NOP) |=> sdram_cmd == sdc_pkg::CMD_NOP && acc_ready)
		else $error("nop mode issued another command");
	a_pre_all: assert property (s_take(sdc_pkg::CM_PRECHARGE) |=> sdram_cmd == sdc_pkg::CMD_PRECHARGE
		&& sdram_a[sdc_pkg::PRE_ALL_BIT])
		else $error("precharge mode did not precharge all banks");
	a_lmr_offset: assert property (s_take(sdc_pkg::CM_LOAD_MODE) |=> sdram_cmd == sdc_pkg::CMD_LOAD_MODE
		&& sdram_a == $past(acc_addr[12:0]))
		else $error("load mode value differs from offset");
	a_ref_mode: assert property (s_take(sdc_pkg::CM_REFRESH) |=> sdram_cmd == sdc_pkg::CMD_REFRESH)
		else $error("refresh mode did not refresh");
	a_normal_act: assert property (s_take(sdc_pkg::CM_NORMAL) |=> sdram_cmd == sdc_pkg::CMD_ACTIVE
		##1 st_r.seq == sdc_pkg::SEQ_RW [*2])
		else $error("normal access did not open a row");
	a_width_lanes: assert property (bus_width_16 |-> sdram_dq_oe[31:16] == 16'h0)
		else $error("upper lanes driven on a 16-bit bus");
	a_timer_reload: assert property (st_r.tick |-> st_r.tmr == st_r.count && $past(st_r.tmr) <= 12'h001)
		else $error("refresh timer did not reload from count");
	a_tick_pend: assert property (st_r.tick |=> st_r.ref_pend)
		else $error("refresh pulse did not queue a refresh");
	a_unarmed_quiet: assert property (!st_r.armed |-> !st_r.tick && !st_r.ref_pend)
		else $error("refresh started before count was written");
	a_missed_error: assert property (st_r.tick && st_r.ref_pend |=> st_r.istat)
		else $error("missed refresh not flagged");
	a_read_clear: assert property (rd_fire && s_araddr == sdc_pkg::OFF_IRQ_STAT && !err_set |=> !st_r.istat)
		else $error("status read did not clear the error");
	a_reserved_zero: assert property (rd_fire && s_araddr >= 8'h24 |=> s_rvalid && s_rdata == 32'h0)
		else $error("reserved offset read nonzero");
	a_irq_level: assert property (##1 irq == ($past(st_nxt.istat) && $past(st_nxt.imask)))
		else $error("interrupt line disagrees with status and mask");

endmodule

// >>> bench/sdc_sdram_model.sv
// sdc_sdram_model: behavioural sdram seen from the controller's command pins
// assumes: commands change only a few master clocks after a link clock rise
module sdc_sdram_model (
	input  wire sdc_pkg::sdc_cmd_type sdram_cmd,
	input  wire logic [12:0]          sdram_a,
	input  wire logic [1:0]           sdram_ba,
	input  wire logic [31:0]          sdram_dq_out,
	input  wire logic [31:0]          sdram_dq_oe,
	input  wire logic [31:0]          rd_val,       // word returned on a read
	output logic                      sdram_clk_in, // free running link clock
	output logic [31:0]               sdram_dq_in,
	output sdc_pkg::sdc_cmd_type      last_cmd,     // last command other than nop
	output logic [14:0]               last_addr,    // {ba, a} of that command
	output logic [12:0]               col_a,        // address of last read or write
	output logic [31:0]               wr_data,      // driven lanes of last write
	output int                        n_cmd,
	output int                        n_ref
);
	timeunit 1ns;
	timeprecision 100ps;
	// ****************************************
	// link clock and command sampling
	// ****************************************
	// sdram clock runs free, phase unrelated to the master clock
	initial begin
		sdram_clk_in = 1'b0;
		#37;
		forever #80 sdram_clk_in = ~sdram_clk_in;
	end
	// sample pins half a link period after launch, when they are settled
	initial begin
		sdram_dq_in = 32'h0;
		n_cmd = 0;
		n_ref = 0;
		forever begin
			@(negedge sdram_clk_in);
			sdram_dq_in = ~sdram_dq_in;                  // undriven bus keeps moving
			if (sdram_cmd !== sdc_pkg::CMD_NOP) begin
				n_cmd++;
				last_cmd = sdram_cmd;
				last_addr = {sdram_ba, sdram_a};
			end
			if (sdram_cmd === sdc_pkg::CMD_REFRESH) n_ref++;
			if (sdram_cmd === sdc_pkg::CMD_READ || sdram_cmd === sdc_pkg::CMD_WRITE) col_a = sdram_a;
			if (sdram_cmd === sdc_pkg::CMD_WRITE) wr_data = sdram_dq_out & sdram_dq_oe;
			// read data held for one link period, latency folded in
			if (sdram_cmd === sdc_pkg::CMD_READ) sdram_dq_in = rd_val;
		end
	end
endmodule

// >>> bench/tb.sv
// tb: self-checking bench of the command mode and refresh block
// assumes: axi4-lite master here, sdram model on the far side
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	// ****************************************
	// signals and instances
	// ****************************************
	logic                 clock, reset, s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
	logic                 s_arvalid, s_arready, s_rvalid, s_rready, acc_valid, acc_write, acc_ready;
	logic                 sdram_clk_in, bus_width_16, irq;
	logic [7:0]           s_awaddr, s_araddr;
	logic [31:0]          s_wdata, s_rdata, acc_wdata, acc_rdata, sdram_dq_in, sdram_dq_out, sdram_dq_oe;
	logic [31:0]          rd_val, wr_data, d, e;
	logic [3:0]           s_wstrb;
	logic [1:0]           s_bresp, s_rresp, sdram_ba;
	logic [25:0]          acc_addr;
	logic [12:0]          sdram_a, col_a;
	logic [14:0]          last_addr;
	sdc_pkg::sdc_cmd_type sdram_cmd, last_cmd;
	int                   num_errors, comparisons, n_cmd, n_ref, k, c0;
	logic [7:0]           ofs [9] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h1c, 8'h20, 8'h44};
	logic [31:0]          rst [9] = '{32'h10, 32'h800, 32'h2a99c140, 0, 0, 0, 0, 0, 0};
	logic [7:0]           ro [4] = '{8'h0c, 8'h1c, 8'h20, 8'h80};
	sdc_mode_refresh i_sdc_mode_refresh (.clock, .reset, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb,
		.s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata,
		.s_rresp, .s_rvalid, .s_rready, .acc_valid, .acc_write, .acc_addr, .acc_wdata, .acc_ready, .acc_rdata,
		.sdram_clk_in, .sdram_cmd, .sdram_a, .sdram_ba, .sdram_dq_in, .sdram_dq_out, .sdram_dq_oe,
		.bus_width_16, .irq);
	sdc_sdram_model i_sdc_sdram_model (.sdram_cmd, .sdram_a, .sdram_ba, .sdram_dq_out, .sdram_dq_oe, .rd_val,
		.sdram_clk_in, .sdram_dq_in, .last_cmd, .last_addr, .col_a, .wr_data, .n_cmd, .n_ref);
	// master clock, 8 ns
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	// ****************************************
	// tasks
	// ****************************************
	task automatic results;
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		comparisons++;
		if (g !== x) begin
			num_errors++;
			$display("unexpected at %0t: got %h want %h", $time, g, x);
		end
	endtask
	// write: address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clock);
		s_awaddr <= a;
		s_wdata <= v;
		s_awvalid <= 1'b1;
		s_wvalid <= 1'b1;
		s_bready <= 1'b1;
		do begin
			@(posedge clock);
			if (s_awready === 1'b1) s_awvalid <= 1'b0;
			if (s_wready === 1'b1) s_wvalid <= 1'b0;
		end while (s_bvalid !== 1'b1);
		chk(s_bresp, 2'h0);
		s_bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clock);
		s_araddr <= a;
		s_arvalid <= 1'b1;
		s_rready <= 1'b1;
		do begin
			@(posedge clock);
			if (s_arready === 1'b1) s_arvalid <= 1'b0;
		end while (s_rvalid !== 1'b1);
		v = s_rdata;
		chk(s_rresp, 2'h0);
		s_rready <= 1'b0;
	endtask
	// sdram space access, held until the done pulse, then let the model sample
	task automatic acc(input logic w, input logic [25:0] a);
		@(posedge clock);
		acc_write <= w;
		acc_addr <= a;
		acc_wdata <= $urandom;
		acc_valid <= 1'b1;
		do @(posedge clock); while (acc_ready !== 1'b1);
		acc_valid <= 1'b0;
		d = acc_rdata;
		repeat (25) @(posedge clock);
	endtask
	// expected command for a forced mode
	function automatic sdc_pkg::sdc_cmd_type exp_cmd(input int m);
		case (m)
			2: return sdc_pkg::CMD_PRECHARGE;
			3: return sdc_pkg::CMD_LOAD_MODE;
			default: return sdc_pkg::CMD_REFRESH;
		endcase
	endfunction
	// ****************************************
	// tests
	// ****************************************
	initial begin
		reset = 1'b1;
		{s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, acc_valid, acc_write} = '0;
		{s_awaddr, s_araddr, s_wdata, acc_addr, acc_wdata, rd_val} = '0;
		s_wstrb = 4'hf;
		num_errors = 0;
		comparisons = 0;
		void'($urandom(32'h5c615b69));
		repeat (20) @(posedge clock);
		reset <= 1'b0;
		repeat (3) @(posedge clock);
		foreach (ofs[i]) begin
			rd(ofs[i], e);
			chk(e, rst[i]);
		end
		chk(bus_width_16, 1);
		foreach (ro[i]) begin
			wr(ro[i], $urandom);
			rd(ro[i], e);
			chk(e, 0);
		end
		repeat (3000) @(posedge clock);
		chk(n_ref, 0);
		// precharge mode runs before refresh mode
		for (int m = 1; m <= 5; m++) begin
			wr(8'h00, 32'h10 | m);
			c0 = n_cmd;
			k = $urandom;
			acc(k[4], k[25:0]);
			chk(n_cmd - c0, (m == 1 || m == 5) ? 0 : 1);
			if (m > 1 && m < 5) chk(last_cmd, exp_cmd(m));
			if (m == 2) chk(last_addr[12:0], 32'h400);
			if (m == 3) chk(last_addr, k[14:0]);
		end
		for (int w = 0; w < 2; w++) begin
			wr(8'h00, w << 4);
			chk(bus_width_16, w);
			k = $urandom;
			rd_val <= $urandom;
			c0 = n_cmd;
			acc(1'b0, k[25:0]);
			chk(d, w ? {16'h0, rd_val[15:0]} : rd_val);
			chk(col_a, w ? k[10:1] : k[11:2]);
			chk(n_cmd - c0, 3);
			chk(last_cmd, sdc_pkg::CMD_PRECHARGE);
			acc(1'b1, k[25:0]);
			chk(wr_data, w ? {16'h0, acc_wdata[15:0]} : acc_wdata);
		end
		// interval at least two link periods so no refresh is missed
		k = 40 + $urandom % 40;
		wr(8'h04, k);
		c0 = n_ref;
		repeat (20 * k) @(posedge clock);
		chk((n_ref - c0) inside {[19:21]}, 1);
		rd(8'h04, e);
		chk(e, k);
		wr(8'h04, 1);
		repeat (30) @(posedge clock);
		wr(8'h04, 0);
		repeat (30) @(posedge clock);
		chk(irq, 0);
		wr(8'h14, 1);
		repeat (2) @(posedge clock);
		chk(irq, 1);
		rd(8'h1c, e);
		chk(e, 1);
		rd(8'h20, e);
		chk(e, 1);
		rd(8'h20, e);
		chk(e, 0);
		repeat (2) @(posedge clock);
		chk(irq, 0);
		wr(8'h18, 1);
		rd(8'h1c, e);
		chk(e, 0);
		results;
	end
	// watchdog, well beyond the expected run
	initial begin
		#200000;
		num_errors++;
		results;
	end
endmodule
